// [inc/swc_pkg.sv]
`default_nettype none
package swc_pkg;
  // Register offsets on the controller port and in SPI register commands.
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_WIN_CFG = 8'h14;
  localparam logic [7:0] OFF_W0_BASE = 8'h18;
  localparam logic [7:0] OFF_W0_WLIM = 8'h1C;
  localparam logic [7:0] OFF_W0_RLIM = 8'h20;
  localparam logic [7:0] OFF_W1_BASE = 8'h24;
  localparam logic [7:0] OFF_W1_WLIM = 8'h28;
  localparam logic [7:0] OFF_W1_RLIM = 8'h2C;
  // Interrupt enable bit positions.
  localparam int IE_WR_DONE = 0;
  localparam int IE_RD_DONE = 1;
  localparam int IE_WR_BUSY = 3;
  localparam int IE_RD_BUSY = 4;
  localparam int IE_SREG_BUSY = 5;
  localparam int IE_OOL0 = 19;
  localparam int IE_OOL1 = 20;
  // Writable bit masks; all other bits are reserved and read as zero.
  localparam logic [31:0] IRQ_EN_MASK = 32'h0018_003B;
  localparam logic [31:0] WIN_CFG_MASK = 32'h0000_0003;
  localparam logic [31:0] BASE_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] LIMIT_MASK = 32'h0000_7FFC;
  localparam int CFG_EN0 = 0;
  localparam int CFG_EN1 = 1;
  // Reset values.
  localparam logic [31:0] RST_IRQ_EN = 32'h0000_0000;
  localparam logic [31:0] RST_WIN_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;
  // SPI frame layout: one command byte, then one 32-bit word, MSB first.
  localparam int CMD_BITS = 8;
  localparam int WORD_BITS = 32;
  localparam int FRAME_BITS = 40;
  localparam int CMD_MEM_BIT = 7;
  localparam int CMD_WR_BIT = 6;
  localparam logic [5:0] CNT_CMD_DONE = 6'h08;
  localparam logic [5:0] CNT_FRAME_DONE = 6'h28;
endpackage
`default_nettype wire

// [verilog/swc_spi_frame.sv]
`default_nettype none
module swc_spi_frame (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // SPI pins, mode 0.
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Decoded frame toward the register logic.
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic frame_valid,
  output logic [31:0] frame_word,
  input wire logic [31:0] reply_word
);
  logic [2:0] sck_s, cs_s, mosi_s;
  logic [5:0] cnt, next_cnt;
  logic [39:0] shift, next_shift;
  logic [31:0] tx, next_tx;
  logic tx_loaded, next_tx_loaded;
  logic next_miso, next_cmd_valid, next_frame_valid;
  logic [7:0] next_cmd_byte;
  logic [31:0] next_frame_word;
  logic rise, fall, active;

  // Pins cross into core_clk through two flops; edges use flops two and three.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sck_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 3'h0;
    end
    else
    begin
      sck_s <= {sck_s[1:0], spi_sck};
      cs_s <= {cs_s[1:0], spi_cs_n};
      mosi_s <= {mosi_s[1:0], spi_mosi};
    end
  end

  assign active = !cs_s[1];
  assign rise = active && sck_s[1] && !sck_s[2];
  assign fall = active && !sck_s[1] && sck_s[2];

  always_comb
  begin
    next_cnt = cnt;
    next_shift = shift;
    next_tx = tx;
    next_tx_loaded = tx_loaded;
    next_miso = spi_miso;
    next_cmd_valid = 1'b0;
    next_frame_valid = 1'b0;
    next_cmd_byte = cmd_byte;
    next_frame_word = frame_word;
    if (!active)
    begin
      next_cnt = 6'h00;
      next_tx_loaded = 1'b0;
      next_miso = 1'b0;
    end
    else if (rise && cnt != swc_pkg::CNT_FRAME_DONE)
    begin
      next_shift = {shift[38:0], mosi_s[1]};
      next_cnt = cnt + 6'h01;
      if (next_cnt == swc_pkg::CNT_CMD_DONE)
      begin
        next_cmd_valid = 1'b1;
        next_cmd_byte = next_shift[7:0];
      end
      if (next_cnt == swc_pkg::CNT_FRAME_DONE)
      begin
        next_frame_valid = 1'b1;
        next_frame_word = next_shift[31:0];
      end
    end
    else if (fall && cnt >= swc_pkg::CNT_CMD_DONE)
    begin
      // The reply is taken a half SCK period after the command byte, by
      // which time the register side has long since registered it.
      if (!tx_loaded)
      begin
        next_tx = {reply_word[30:0], 1'b0};
        next_miso = reply_word[31];
        next_tx_loaded = 1'b1;
      end
      else
      begin
        next_tx = {tx[30:0], 1'b0};
        next_miso = tx[31];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt <= 6'h00;
      shift <= 40'h00_0000_0000;
      tx <= 32'h0000_0000;
      tx_loaded <= 1'b0;
      spi_miso <= 1'b0;
      cmd_valid <= 1'b0;
      frame_valid <= 1'b0;
      cmd_byte <= 8'h00;
      frame_word <= 32'h0000_0000;
    end
    else
    begin
      cnt <= next_cnt;
      shift <= next_shift;
      tx <= next_tx;
      tx_loaded <= next_tx_loaded;
      spi_miso <= next_miso;
      cmd_valid <= next_cmd_valid;
      frame_valid <= next_frame_valid;
      cmd_byte <= next_cmd_byte;
      frame_word <= next_frame_word;
    end
  end
endmodule
`default_nettype wire

// [verilog/swc_window_cfg.sv]
`default_nettype none
module swc_window_cfg (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Controller register port.
  input wire logic ec_wr_en,
  input wire logic ec_rd_en,
  input wire logic [7:0] ec_addr,
  input wire logic [31:0] ec_wdata,
  output logic [31:0] ec_rdata,
  // SPI pins.
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Status flags and lock bits from the rest of the unit.
  input wire logic status_reg_xfer_busy,
  input wire logic mem_read_busy,
  input wire logic mem_write_busy,
  input wire logic mem_read_done,
  input wire logic mem_write_done,
  input wire logic window0_addr_lock,
  input wire logic window1_addr_lock,
  // Out-of-limit flags and their clears.
  input wire logic [1:0] out_of_limit_clr,
  output logic [1:0] out_of_limit,
  // Accepted memory access toward the controller memory bus.
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  // Interrupt toward the embedded controller.
  output logic embedded_controller_irq
);
  logic [31:0] irq_en, next_irq_en;
  logic [31:0] win_cfg, next_win_cfg;
  logic [1:0][31:0] base, next_base;
  logic [1:0][31:0] wlim, next_wlim;
  logic [1:0][31:0] rlim, next_rlim;
  logic [1:0] next_ool;
  logic [31:0] next_ec_rdata, spi_reply, next_spi_reply;
  logic next_mem_req, next_mem_write;
  logic [31:0] next_mem_addr;
  logic cmd_valid, frame_valid;
  logic [7:0] cmd_byte;
  logic [31:0] frame_word;
  logic [1:0] wr_v, wr_spi;
  logic [1:0][7:0] wr_a;
  logic [1:0][31:0] wr_d;
  logic [1:0] lock;
  logic [1:0][31:0] lim_sel;
  logic [1:0] hit;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      swc_pkg::OFF_IRQ_EN: reg_read = irq_en;
      swc_pkg::OFF_WIN_CFG: reg_read = win_cfg;
      swc_pkg::OFF_W0_BASE: reg_read = base[0];
      swc_pkg::OFF_W0_WLIM: reg_read = wlim[0];
      swc_pkg::OFF_W0_RLIM: reg_read = rlim[0];
      swc_pkg::OFF_W1_BASE: reg_read = base[1];
      swc_pkg::OFF_W1_WLIM: reg_read = wlim[1];
      swc_pkg::OFF_W1_RLIM: reg_read = rlim[1];
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  // The limit is an exclusive byte count above the base.
  function automatic logic in_window(input logic en, input logic [31:0] b,
    input logic [31:0] lim, input logic [31:0] a);
    logic [31:0] off;
    off = a - b;
    in_window = en && (a >= b) && (off < lim);
  endfunction

  swc_spi_frame u_frame (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte),
    .frame_valid(frame_valid),
    .frame_word(frame_word),
    .reply_word(spi_reply)
  );

  assign lock = {window1_addr_lock, window0_addr_lock};

  // Register writes: SPI is source 0, controller is source 1 and wins.
  always_comb
  begin
    wr_v[0] = frame_valid && !cmd_byte[swc_pkg::CMD_MEM_BIT]
      && cmd_byte[swc_pkg::CMD_WR_BIT];
    wr_a[0] = {cmd_byte[5:0], 2'b00};
    wr_d[0] = frame_word;
    wr_spi[0] = 1'b1;
    wr_v[1] = ec_wr_en;
    wr_a[1] = ec_addr;
    wr_d[1] = ec_wdata;
    wr_spi[1] = 1'b0;
    next_irq_en = irq_en;
    next_win_cfg = win_cfg;
    next_base = base;
    next_wlim = wlim;
    next_rlim = rlim;
    for (int s = 0; s < 2; s++)
    begin
      if (wr_v[s])
      begin
        for (int w = 0; w < 2; w++)
        begin
          // Locked window address registers ignore the SPI master.
          if (!(wr_spi[s] && lock[w]))
          begin
            if (wr_a[s] == (w == 0 ? swc_pkg::OFF_W0_BASE
              : swc_pkg::OFF_W1_BASE))
              next_base[w] = wr_d[s] & swc_pkg::BASE_MASK;
            if (wr_a[s] == (w == 0 ? swc_pkg::OFF_W0_WLIM
              : swc_pkg::OFF_W1_WLIM))
              next_wlim[w] = wr_d[s] & swc_pkg::LIMIT_MASK;
            if (wr_a[s] == (w == 0 ? swc_pkg::OFF_W0_RLIM
              : swc_pkg::OFF_W1_RLIM))
              next_rlim[w] = wr_d[s] & swc_pkg::LIMIT_MASK;
          end
        end
        if (wr_a[s] == swc_pkg::OFF_IRQ_EN)
          next_irq_en = wr_d[s] & swc_pkg::IRQ_EN_MASK;
        if (wr_a[s] == swc_pkg::OFF_WIN_CFG)
          next_win_cfg = wr_d[s] & swc_pkg::WIN_CFG_MASK;
      end
    end
  end

  // Window check for SPI memory frames; a miss flags window one if enabled and at or above its base, else window zero.
  always_comb
  begin
    next_ool = out_of_limit & ~out_of_limit_clr;
    next_mem_req = 1'b0;
    next_mem_write = mem_write;
    next_mem_addr = mem_addr;
    for (int w = 0; w < 2; w++)
    begin
      lim_sel[w] = cmd_byte[swc_pkg::CMD_WR_BIT] ? wlim[w] : rlim[w];
      hit[w] = in_window(win_cfg[w], base[w], lim_sel[w], frame_word);
    end
    if (frame_valid && cmd_byte[swc_pkg::CMD_MEM_BIT])
    begin
      if (hit[0] || hit[1])
      begin
        next_mem_req = 1'b1;
        next_mem_write = cmd_byte[swc_pkg::CMD_WR_BIT];
        next_mem_addr = frame_word;
      end
      else if (win_cfg[swc_pkg::CFG_EN1] && frame_word >= base[1])
        next_ool[1] = 1'b1;
      else
        next_ool[0] = 1'b1;
    end
    next_ec_rdata = ec_rd_en ? reg_read(ec_addr) : ec_rdata;
    next_spi_reply = cmd_valid ? reg_read({cmd_byte[5:0], 2'b00})
      : spi_reply;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      irq_en <= swc_pkg::RST_IRQ_EN;
      win_cfg <= swc_pkg::RST_WIN_CFG;
      base <= {2{swc_pkg::RST_BASE}};
      wlim <= {2{swc_pkg::RST_LIMIT}};
      rlim <= {2{swc_pkg::RST_LIMIT}};
      out_of_limit <= 2'h0;
      ec_rdata <= 32'h0000_0000;
      spi_reply <= 32'h0000_0000;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 32'h0000_0000;
    end
    else
    begin
      irq_en <= next_irq_en;
      win_cfg <= next_win_cfg;
      base <= next_base;
      wlim <= next_wlim;
      rlim <= next_rlim;
      out_of_limit <= next_ool;
      ec_rdata <= next_ec_rdata;
      spi_reply <= next_spi_reply;
      mem_req <= next_mem_req;
      mem_write <= next_mem_write;
      mem_addr <= next_mem_addr;
    end
  end

  // Level interrupt; it falls as soon as the flag or its enable clears.
  always_comb
  begin
    embedded_controller_irq =
      (status_reg_xfer_busy && irq_en[swc_pkg::IE_SREG_BUSY])
      || (mem_read_busy && irq_en[swc_pkg::IE_RD_BUSY])
      || (mem_write_busy && irq_en[swc_pkg::IE_WR_BUSY])
      || (mem_read_done && irq_en[swc_pkg::IE_RD_DONE])
      || (mem_write_done && irq_en[swc_pkg::IE_WR_DONE])
      || (out_of_limit[0] && irq_en[swc_pkg::IE_OOL0])
      || (out_of_limit[1] && irq_en[swc_pkg::IE_OOL1]);
  end
endmodule
`default_nettype wire

// [verification/swc_window_cfg_checker.sv]
`default_nettype none
module swc_window_cfg_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Controller port.
  input wire logic ec_wr_en,
  input wire logic ec_rd_en,
  input wire logic [7:0] ec_addr,
  input wire logic [31:0] ec_wdata,
  input wire logic [31:0] ec_rdata,
  // Link and status.
  input wire logic spi_cs_n,
  input wire logic status_reg_xfer_busy,
  input wire logic mem_read_busy,
  input wire logic mem_write_busy,
  input wire logic mem_read_done,
  input wire logic mem_write_done,
  input wire logic [1:0] out_of_limit_clr,
  input wire logic [1:0] out_of_limit,
  input wire logic mem_req,
  input wire logic embedded_controller_irq
);
  // Shadows track controller writes only, so SPI writes to these two
  // registers would make them drift.
  logic [31:0] ie, next_ie, flg;
  logic [1:0] cfg, next_cfg;
  assign flg = {11'h0, out_of_limit, 13'h0, status_reg_xfer_busy,
    mem_read_busy, mem_write_busy, 1'h0, mem_read_done, mem_write_done};
  always_comb
  begin
    next_ie = ie;
    next_cfg = cfg;
    if (ec_wr_en && ec_addr == swc_pkg::OFF_IRQ_EN)
      next_ie = ec_wdata & swc_pkg::IRQ_EN_MASK;
    if (ec_wr_en && ec_addr == swc_pkg::OFF_WIN_CFG)
      next_cfg = ec_wdata[1:0];
  end
  always_ff @(posedge core_clk)
  begin
    ie <= sys_rst ? 32'h0 : next_ie;
    cfg <= sys_rst ? 2'h0 : next_cfg;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  AST_IRQ_GATE:
    assert property (embedded_controller_irq == |(flg & ie))
    else $error("irq differs from gated flags");
  AST_UNMAPPED: assert property (ec_rd_en && ec_addr > 8'h2C
    |=> ec_rdata == 32'h0) else $error("unmapped read not zero");
  AST_CFG_READ: assert property (ec_rd_en && ec_addr == 8'h14
    |=> ec_rdata == {30'h0, cfg}) else $error("window enables wrong");
  AST_BASE_RSVD: assert property (ec_rd_en
    && ec_addr inside {8'h18, 8'h24}
    |=> ec_rdata[1:0] == 2'h0) else $error("base low bits set");
  AST_LIM_RSVD: assert property (ec_rd_en
    && ec_addr inside {8'h1C, 8'h20, 8'h28, 8'h2C}
    |=> (ec_rdata & ~swc_pkg::LIMIT_MASK) == 32'h0)
    else $error("limit reserved bits set");
  AST_REQ_PULSE: assert property (mem_req |=> !mem_req)
    else $error("request longer than one cycle");
  AST_REQ_EN: assert property (mem_req |-> cfg != 2'h0)
    else $error("request with both windows off");
  AST_OOL_HOLD: assert property (out_of_limit[0]
    && !out_of_limit_clr[0] |=> out_of_limit[0])
    else $error("error flag dropped");
  AST_IDLE: assert property (spi_cs_n [*8] |-> !mem_req)
    else $error("request without a frame");
endmodule
bind swc_window_cfg swc_window_cfg_checker u_chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .ec_wr_en(ec_wr_en), .ec_rd_en(ec_rd_en),
  .ec_addr(ec_addr), .ec_wdata(ec_wdata), .ec_rdata(ec_rdata),
  .spi_cs_n(spi_cs_n), .status_reg_xfer_busy(status_reg_xfer_busy),
  .mem_read_busy(mem_read_busy), .mem_write_busy(mem_write_busy),
  .mem_read_done(mem_read_done), .mem_write_done(mem_write_done),
  .out_of_limit_clr(out_of_limit_clr), .out_of_limit(out_of_limit),
  .mem_req(mem_req), .embedded_controller_irq(embedded_controller_irq));
`default_nettype wire

// [verification/swc_spi_master.sv]
`default_nettype none
module swc_spi_master (
  // SPI pins.
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    spi_sck = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
  end
  // Clock stands still between frames; MOSI inverts once released.
  task automatic xfer(input logic [39:0] f, output logic [31:0] rx);
    rx = 32'h0;
    spi_cs_n = 1'h0;
    for (int i = 39; i >= 0; i--)
    begin
      spi_mosi = f[i];
      #32 spi_sck = 1'h1;
      if (i < 32)
        rx = {rx[30:0], spi_miso};
      #32 spi_sck = 1'h0;
    end
    #64 spi_cs_n = 1'h1;
    spi_mosi = ~f[0];
    #64;
  endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic ec_wr_en = 1'h0;
  logic ec_rd_en = 1'h0;
  logic [7:0] ec_addr = 8'h00;
  logic [31:0] ec_wdata = 32'h0;
  logic [31:0] ec_rdata, mem_addr, v, d, b, rx;
  logic [4:0] stat = 5'h00;
  logic [1:0] lock = 2'h3;
  logic [1:0] clr = 2'h0;
  logic [1:0] ool, ev;
  logic sck, cs_n, mosi, miso, mem_req, mem_write, irq, ok;
  logic [7:0] offs [9] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
    8'h2C, 8'h30};
  logic [31:0] ma [9] = '{32'h1000, 32'h10FC, 32'h1100, 32'h103C, 32'h1040,
    32'h800C, 32'h8010, 32'h1004, 32'h1000};
  logic [17:0] cgv = 18'h1BD55;
  logic [8:0] mwv = 9'h1E7;
  int pos [5] = '{0, 1, 3, 4, 5};
  int err_count = 0;
  int num_checks = 0;
  int seed = 15;
  int reqs = 0;
  int n;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
    reqs <= reqs + int'(mem_req);
  swc_window_cfg DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .ec_wr_en(ec_wr_en), .ec_rd_en(ec_rd_en), .ec_addr(ec_addr),
    .ec_wdata(ec_wdata), .ec_rdata(ec_rdata), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .status_reg_xfer_busy(stat[4]), .mem_read_busy(stat[3]),
    .mem_write_busy(stat[2]), .mem_read_done(stat[1]),
    .mem_write_done(stat[0]), .window0_addr_lock(lock[0]),
    .window1_addr_lock(lock[1]), .out_of_limit_clr(clr),
    .out_of_limit(ool), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .embedded_controller_irq(irq));
  swc_spi_master spi (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso));
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: word %h, want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: bit %b, want %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge core_clk);
    #1 ec_wr_en = 1'h1;
    ec_addr = a;
    ec_wdata = x;
    @(posedge core_clk);
    #1 ec_wr_en = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge core_clk);
    #1 ec_rd_en = 1'h1;
    ec_addr = a;
    @(posedge core_clk);
    #1 ec_rd_en = 1'h0;
    x = ec_rdata;
  endtask
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h10: return swc_pkg::IRQ_EN_MASK;
      8'h14: return swc_pkg::WIN_CFG_MASK;
      8'h18, 8'h24: return swc_pkg::BASE_MASK;
      8'h30: return 32'h0;
      default: return swc_pkg::LIMIT_MASK;
    endcase
  endfunction
  function automatic logic [39:0] fr(input logic m, input logic w,
    input logic [7:0] a, input logic [31:0] x);
    return {m, w, a[7:2], x};
  endfunction
  // The limit is exclusive, so an offset equal to it is a miss.
  function automatic logic inw(input logic [31:0] a, input logic [31:0] s,
    input logic [31:0] l);
    return a >= s && a - s < l;
  endfunction
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #120000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'h0;
    repeat (4) @(posedge core_clk);
    foreach (offs[i])
    begin
      rd(offs[i], v);
      chk_word(v, 32'h0);
      d = $random(seed);
      wr(offs[i], d);
      rd(offs[i], v);
      chk_word(v, d & msk(offs[i]));
    end
    $display("register test done");
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h10, 32'h1 << pos[k]);
      for (int j = 0; j < 5; j++)
      begin
        stat = 5'h01 << j;
        @(posedge core_clk);
        #1 chk_bit(irq, j == k);
      end
      stat = 5'h00;
    end
    $display("interrupt test done");
    for (int w = 0; w < 2; w++)
    begin
      // Writing the complement guarantees a visible change if not refused.
      rd(w ? 8'h28 : 8'h1C, b);
      spi.xfer(fr(1'h0, 1'h1, w ? 8'h28 : 8'h1C, ~b), rx);
      rd(w ? 8'h28 : 8'h1C, v);
      chk_word(v, b);
      rd(w ? 8'h24 : 8'h18, b);
      d = $random(seed);
      spi.xfer(fr(1'h0, 1'h1, w ? 8'h24 : 8'h18, d), rx);
      rd(w ? 8'h24 : 8'h18, v);
      chk_word(v, b);
      lock[w] = 1'h0;
      spi.xfer(fr(1'h0, 1'h1, w ? 8'h24 : 8'h18, d), rx);
      spi.xfer(fr(1'h0, 1'h0, w ? 8'h24 : 8'h18, 32'h0), rx);
      chk_word(rx, d & swc_pkg::BASE_MASK);
      lock[w] = 1'h1;
    end
    $display("lock test done");
    wr(8'h18, 32'h1000);
    wr(8'h1C, 32'h100);
    wr(8'h20, 32'h40);
    wr(8'h24, 32'h8000);
    wr(8'h28, 32'h10);
    wr(8'h2C, 32'h10);
    wr(8'h10, 32'h0018_0000);
    ma[8] = 32'h1000 | ($random(seed) & 32'h1FC);
    for (int c = 0; c < 9; c++)
    begin
      wr(8'h14, {30'h0, cgv[2*c+:2]});
      n = reqs;
      spi.xfer(fr(1'h1, mwv[c], 8'h00, ma[c]), rx);
      ok = (cgv[2*c] && inw(ma[c], 32'h1000, mwv[c] ? 32'h100 : 32'h40))
        || (cgv[2*c+1] && inw(ma[c], 32'h8000, 32'h10));
      ev = ok ? 2'h0 : (cgv[2*c+1] && ma[c] >= 32'h8000 ? 2'h2 : 2'h1);
      chk_word(32'(reqs - n), {31'h0, ok});
      chk_word({30'h0, ool}, {30'h0, ev});
      chk_bit(irq, !ok);
      if (ok)
      begin
        chk_word(mem_addr, ma[c]);
        chk_bit(mem_write, mwv[c]);
      end
      clr = 2'h3;
      @(posedge core_clk);
      #1 clr = 2'h0;
      chk_bit(irq, 1'h0);
    end
    $display("window test done");
    wrap_up();
  end
endmodule
`default_nettype wire
